// ==== atf_map.svh ====
// Offsets, field positions, reset values and timing counts for the trigger/filter config bank.
// Included by the package only; the register bank uses its macros without an include of its own; holds definitions only.
`ifndef ATF_MAP_SVH
`define ATF_MAP_SVH
`define ATF_OFF_PIN1_CTRL     7'h05
`define ATF_OFF_CONV_SETUP    7'h06
`define ATF_OFF_SEQ_ADDR      7'h07
`define ATF_OFF_FILTER        7'h08
`define ATF_OFF_CTRL          7'h09
`define ATF_RST_PIN1_CTRL     8'h00
`define ATF_RST_CONV_SETUP    8'h00
`define ATF_RST_SEQ_ADDR      7'h3a
`define ATF_RST_FILTER        8'h00
`define ATF_RST_CTRL          8'h01
`define ATF_SEQ_ADDR_MIN      7'h3a
`define ATF_SEQ_ADDR_MAX      7'h6f
`define ATF_DIR_MSB           7
`define ATF_DIR_LSB           6
`define ATF_ISEL_MSB          5
`define ATF_ISEL_LSB          4
`define ATF_OSEL_MSB          2
`define ATF_OSEL_LSB          0
`define ATF_DEST_MSB          6
`define ATF_DEST_LSB          4
`define ATF_CTYPE_MSB         1
`define ATF_CTYPE_LSB         0
`define ATF_FILTER_TYPE_FIELD_MSB         5
`define ATF_FILTER_TYPE_FIELD_LSB         4
`define ATF_RATE_MSB          3
`define ATF_RATE_LSB          0
`define ATF_BIT_EXTERNAL_CLOCK_SELECT        7
`define ATF_BIT_POLARITY      6
`define ATF_BIT_FORMAT        5
`define ATF_MIN_PULSE_CYCLES  2
`endif

// ==== atf_pkg.sv ====
// Types for the trigger/filter configuration bank.
// Assumes atf_map.svh is on the include path.
`include "atf_map.svh"
package atf_pkg;
    typedef enum logic [1:0] {
        ATF_DIR_INPUT = 2'b00, ATF_DIR_RSVD = 2'b01,
        ATF_DIR_OPEN_DRAIN = 2'b10, ATF_DIR_PUSH_PULL = 2'b11
    } atf_dir_t;
    typedef enum logic [1:0] {
        ATF_IN_OFF = 2'b00, ATF_IN_CONV = 2'b01, ATF_IN_SEQ = 2'b10, ATF_IN_RSVD = 2'b11
    } atf_isel_t;
    typedef enum logic [2:0] {
        ATF_OUT_HIZ = 3'b000, ATF_OUT_IRQ_LOW = 3'b001, ATF_OUT_IRQ_HIGH = 3'b010,
        ATF_OUT_ZERO = 3'b011, ATF_OUT_LOW_SWITCH = 3'b100, ATF_OUT_RSVD = 3'b101,
        ATF_OUT_MOD_ACTIVE = 3'b110, ATF_OUT_SYS_CLK = 3'b111
    } atf_osel_t;
    typedef enum logic [1:0] {
        ATF_PWR_NORMAL = 2'b00, ATF_PWR_WAKING = 2'b01
    } atf_wake_state_t;
    // Host serial-port register access, already deserialised
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } atf_reg_req_t;
    // Launch request toward the converter core
    typedef struct packed {
        logic       conv_start;
        logic       seq_start;
        logic [2:0] dest;
        logic [1:0] conv_type;
        logic [6:0] seq_addr;
    } atf_launch_t;
endpackage : atf_pkg

// ==== atf_regs.sv ====
// Trigger pin, triggered-conversion, filter and control configuration register bank.
// Assumes a host-side serial front end delivering decoded register accesses on clk_i,
// and converter core status (power state, sequence busy, interrupt, modulator) on clk_i.
//
// Functional notes
// - Writes with reserved codes in a pin field leave that field unchanged.
// - Pin rising edge in sleep/standby wakes to normal, then launches.
// - Direction bits 7:6: input, reserved, open-drain, push-pull; default input.
// - Input bits 5:4: off, conversion start, sequence start, reserved.
// - Output bits 2:0: high-Z, low irq, high irq, logic zero.
// - Output code 100 is low-side switch, overriding push-pull drive.
// - Code 110 outputs modulator active; 111 outputs system clock.
// - Writing conversion setup only stores, never starts conversion.
// - Triggered result goes to result register chosen by bits 6:4.
// - Conversion type bits 1:0: single, continuous, duty-cycled low power.
// - Writing sequence start address only stores, never launches a sequence.
// - Sequence address resets 0x3A, accepts only 0x3A..0x6F writes.
// - Filter type bits 5:4: 50/60Hz, 50Hz, 60Hz, sinc4.
// - Rate bits 3:0 set data rate, meaning depends on filter type.
// - External clock bit set takes clock from outside, overriding pin0 setup.
// - Clock source bit writes during a running sequence are ignored.
// - Polarity one gives unipolar straight binary; format ignored.
// - Bipolar: format one gives offset binary, zero two's complement.
// - Polarity/format changes leave threshold contents, reinterpret comparisons.
// - Out-of-range inputs saturate at minimum or maximum code.
// - Control bit 7 external clock, 6 unipolar, 5 offset binary; reset zero.
`timescale 1ns/10ps
module atf_regs
    import atf_pkg::*;
#(
    parameter int RESULT_W = 24
) (
    input  wire logic                clk_i,
    input  wire logic                reset_i,
    input  wire logic                clk_en_i,
    input  wire atf_reg_req_t        req_i,
    output logic [7:0]               rdata_o,
    output logic                     rvalid_o,
    input  wire logic                pin1_in_i,
    output logic                     pin1_out_o,
    output logic                     pin1_oe_o,
    input  wire logic                low_power_i,
    output logic                     wake_o,
    output atf_launch_t              launch_o,
    input  wire logic                seq_busy_i,
    input  wire logic                irq_i,
    input  wire logic                mod_active_i,
    input  wire logic                sys_clk_div_i,
    input  wire logic                low_switch_i,
    input  wire logic                raw_valid_i,
    input  wire logic signed [RESULT_W+1:0] raw_i,
    output logic [RESULT_W-1:0]      result_o,
    output logic                     result_valid_o,
    output logic                     ext_clk_sel_o,
    output logic                     unipolar_o,
    output logic                     offset_binary_o,
    output logic [1:0]               filter_type_o,
    output logic [3:0]               rate_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    // Reserved bits are stored as zero, so read-back needs no masking
    logic [7:0] pin1_ctrl;
    logic [7:0] conv_setup;
    logic [6:0] seq_addr;
    logic [7:0] filter_sel;
    logic [7:0] ctrl;

    // Decode of the host access
    // Writes are qualified by the clock enable in the register process
    wire hit_pin1   = req_i.wr && (req_i.addr == `ATF_OFF_PIN1_CTRL);
    wire hit_conv   = req_i.wr && (req_i.addr == `ATF_OFF_CONV_SETUP);
    wire hit_seq    = req_i.wr && (req_i.addr == `ATF_OFF_SEQ_ADDR);
    wire hit_filter = req_i.wr && (req_i.addr == `ATF_OFF_FILTER);
    wire hit_ctrl   = req_i.wr && (req_i.addr == `ATF_OFF_CTRL);

    // Reserved codes are rejected field by field, not for the whole byte
    wire [1:0] wr_dir  = req_i.wdata[`ATF_DIR_MSB:`ATF_DIR_LSB];
    wire [1:0] wr_isel = req_i.wdata[`ATF_ISEL_MSB:`ATF_ISEL_LSB];
    wire [2:0] wr_osel = req_i.wdata[`ATF_OSEL_MSB:`ATF_OSEL_LSB];
    wire       dir_ok  = wr_dir != ATF_DIR_RSVD;
    wire       isel_ok = wr_isel != ATF_IN_RSVD;
    wire       osel_ok = wr_osel != ATF_OUT_RSVD;

    // A refused field keeps its stored code; the other fields still take the write
    wire [7:0] next_pin1_ctrl = {
        dir_ok  ? wr_dir  : pin1_ctrl[`ATF_DIR_MSB:`ATF_DIR_LSB],
        isel_ok ? wr_isel : pin1_ctrl[`ATF_ISEL_MSB:`ATF_ISEL_LSB],
        1'b0,
        osel_ok ? wr_osel : pin1_ctrl[`ATF_OSEL_MSB:`ATF_OSEL_LSB]};

    // Only in-window sequence addresses are stored
    // Bit 7 set counts as out of window; the stored field is seven bits
    wire [6:0] wr_addr7 = req_i.wdata[6:0];
    wire seq_ok = (wr_addr7 >= `ATF_SEQ_ADDR_MIN) && (wr_addr7 <= `ATF_SEQ_ADDR_MAX)
                  && !req_i.wdata[7];

    // Clock source bit frozen while a sequence runs, other bits still written
    wire ext_clk_next = seq_busy_i ? ctrl[`ATF_BIT_EXTERNAL_CLOCK_SELECT]
                                   : req_i.wdata[`ATF_BIT_EXTERNAL_CLOCK_SELECT];

    // Polarity, format, buffer and reference bits pass straight through
    wire [7:0] next_ctrl = {ext_clk_next, req_i.wdata[6:0]};

    // Register writes; plain stores, no launch side effects
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pin1_ctrl  <= `ATF_RST_PIN1_CTRL;
            conv_setup <= `ATF_RST_CONV_SETUP;
            seq_addr   <= `ATF_RST_SEQ_ADDR;
            filter_sel <= `ATF_RST_FILTER;
            ctrl       <= `ATF_RST_CTRL;
        end else if (clk_en_i) begin
            if (hit_pin1) pin1_ctrl <= next_pin1_ctrl;
            if (hit_conv) conv_setup <= {1'b0, req_i.wdata[6:4], 2'b00, req_i.wdata[1:0]};
            if (hit_seq && seq_ok) seq_addr <= wr_addr7;
            if (hit_filter) filter_sel <= {2'b00, req_i.wdata[5:0]};
            if (hit_ctrl) ctrl <= next_ctrl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read-back, one cycle after the request
    // Unmapped offsets read as zero so a stray read is harmless
    wire [7:0] rd_mux =
        (req_i.addr == `ATF_OFF_PIN1_CTRL)  ? pin1_ctrl :
        (req_i.addr == `ATF_OFF_CONV_SETUP) ? conv_setup :
        (req_i.addr == `ATF_OFF_SEQ_ADDR)   ? {1'b0, seq_addr} :
        (req_i.addr == `ATF_OFF_FILTER)     ? filter_sel :
        (req_i.addr == `ATF_OFF_CTRL)       ? ctrl : 8'h00;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_o  <= 8'h00;
            rvalid_o <= 1'b0;
        end else if (clk_en_i) begin
            rdata_o  <= req_i.rd ? rd_mux : 8'h00;
            rvalid_o <= req_i.rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin input: two-stage synchroniser then edge detect on stages two and three
    // Only the second stage reads the first; the third is the edge history
    logic sync_a;
    logic sync_b;
    logic sync_c;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
        end else if (clk_en_i) begin
            sync_a <= pin1_in_i;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // A pulse shorter than two clocks may slip past the sampler
    // Edges are gated by direction so an output pin never triggers
    wire       is_input = pin1_ctrl[`ATF_DIR_MSB:`ATF_DIR_LSB] == ATF_DIR_INPUT;
    wire [1:0] isel     = pin1_ctrl[`ATF_ISEL_MSB:`ATF_ISEL_LSB];
    wire       rise     = sync_b && !sync_c && is_input;
    wire       trig_conv = rise && (isel == ATF_IN_CONV);
    wire       trig_seq  = rise && (isel == ATF_IN_SEQ);

    ////////////////////////////////////////////////////////////////////////////
    // Wake sequencing: in low power, request normal mode first, launch after
    atf_wake_state_t wake_state;
    atf_wake_state_t next_wake_state;
    logic            pend_seq;
    logic            fire_conv;
    logic            fire_seq;

    // Triggers arriving while waking are dropped; the first one is kept,
    // and a sequence trigger wins over a conversion trigger
    always_comb begin
        next_wake_state = wake_state;
        fire_conv = 1'b0;
        fire_seq  = 1'b0;
        case (wake_state)
            ATF_PWR_NORMAL: begin
                if ((trig_conv || trig_seq) && low_power_i) begin
                    next_wake_state = ATF_PWR_WAKING;
                end else begin
                    fire_conv = trig_conv;
                    fire_seq  = trig_seq;
                end
            end
            ATF_PWR_WAKING: begin
                if (!low_power_i) begin
                    next_wake_state = ATF_PWR_NORMAL;
                    fire_conv = !pend_seq;
                    fire_seq  = pend_seq;
                end
            end
            default: next_wake_state = ATF_PWR_NORMAL;
        endcase
    end

    // Launch fields refresh every cycle, so they trail the registers by one
    // cycle; only the two start bits are pulses
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wake_state <= ATF_PWR_NORMAL;
            pend_seq   <= 1'b0;
            wake_o     <= 1'b0;
            launch_o   <= '0;
        end else if (clk_en_i) begin
            wake_state <= next_wake_state;
            if (wake_state == ATF_PWR_NORMAL) pend_seq <= trig_seq;
            wake_o     <= next_wake_state == ATF_PWR_WAKING;
            launch_o.conv_start <= fire_conv;
            launch_o.seq_start  <= fire_seq;
            launch_o.dest       <= conv_setup[`ATF_DEST_MSB:`ATF_DEST_LSB];
            launch_o.conv_type  <= conv_setup[`ATF_CTYPE_MSB:`ATF_CTYPE_LSB];
            launch_o.seq_addr   <= seq_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin output selection
    wire [2:0] osel = pin1_ctrl[`ATF_OSEL_MSB:`ATF_OSEL_LSB];
    wire [1:0] dir  = pin1_ctrl[`ATF_DIR_MSB:`ATF_DIR_LSB];
    wire out_level =
        (osel == ATF_OUT_IRQ_LOW)    ? !irq_i :
        (osel == ATF_OUT_IRQ_HIGH)   ? irq_i :
        (osel == ATF_OUT_LOW_SWITCH) ? 1'b0 :
        (osel == ATF_OUT_MOD_ACTIVE) ? mod_active_i :
        (osel == ATF_OUT_SYS_CLK)    ? sys_clk_div_i : 1'b0;
    wire out_active = dir[1] && (osel != ATF_OUT_HIZ);
    // Push-pull drives both levels whenever an output function other than high-Z or the low-side switch is chosen
    // Open-drain drives only the low level; a high level releases the pin
    // Low-side switch only ever sinks, whatever the drive type
    wire sink_only  = (osel == ATF_OUT_LOW_SWITCH) || (dir == ATF_DIR_OPEN_DRAIN);
    wire next_oe    = out_active && (osel == ATF_OUT_LOW_SWITCH ? low_switch_i
                                    : (sink_only ? !out_level : 1'b1));

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pin1_out_o <= 1'b0;
            pin1_oe_o  <= 1'b0;
        end else if (clk_en_i) begin
            pin1_out_o <= sink_only ? 1'b0 : out_level;
            pin1_oe_o  <= next_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result coding: clamp, then choose straight, offset or two's complement
    // Two guard bits on the raw value keep overflow visible until the clamp
    localparam logic signed [RESULT_W+1:0] MAX_S = (RESULT_W+2)'((1 << (RESULT_W-1)) - 1);
    localparam logic signed [RESULT_W+1:0] MIN_S = -(RESULT_W+2)'(1 << (RESULT_W-1));
    localparam logic signed [RESULT_W+1:0] MAX_U = (RESULT_W+2)'((1 << RESULT_W) - 1);
    wire uni = ctrl[`ATF_BIT_POLARITY];
    wire ofs = ctrl[`ATF_BIT_FORMAT];
    // Unipolar input maps 0..full scale; no wrap on overflow
    wire signed [RESULT_W+1:0] clamp_u = raw_i < 0 ? '0 : (raw_i > MAX_U ? MAX_U : raw_i);
    wire signed [RESULT_W+1:0] clamp_b = raw_i < MIN_S ? MIN_S : (raw_i > MAX_S ? MAX_S : raw_i);
    wire [RESULT_W-1:0] bip_code = clamp_b[RESULT_W-1:0];
    // Offset binary is two's complement with the sign bit flipped
    wire [RESULT_W-1:0] next_result =
        uni ? clamp_u[RESULT_W-1:0] :
        (ofs ? {~bip_code[RESULT_W-1], bip_code[RESULT_W-2:0]} : bip_code);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            result_o       <= '0;
            result_valid_o <= 1'b0;
        end else if (clk_en_i) begin
            if (raw_valid_i) result_o <= next_result;
            result_valid_o <= raw_valid_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration outputs to the clock and filter blocks
    // Threshold registers live elsewhere and are never touched here
    // Format is masked in unipolar mode so downstream sees a single coding
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ext_clk_sel_o   <= 1'b0;
            unipolar_o      <= 1'b0;
            offset_binary_o <= 1'b0;
            filter_type_o   <= 2'b00;
            rate_o          <= 4'h0;
        end else if (clk_en_i) begin
            ext_clk_sel_o   <= ctrl[`ATF_BIT_EXTERNAL_CLOCK_SELECT];
            unipolar_o      <= uni;
            offset_binary_o <= ofs && !uni;
            filter_type_o   <= filter_sel[`ATF_FILTER_TYPE_FIELD_MSB:`ATF_FILTER_TYPE_FIELD_LSB];
            rate_o          <= filter_sel[`ATF_RATE_MSB:`ATF_RATE_LSB];
        end
    end

endmodule : atf_regs

// ==== atf_core_model.sv ====
// Converter core stand-in: power mode and sequencer busy.
// Assumes the bench pulses sleep_i; wake_i and seq_go_i come from the bank.
`timescale 1ns/10ps
module atf_core_model (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic sleep_i,
    input  wire logic wake_i,
    input  wire logic seq_go_i,
    output logic      low_power_o,
    output logic      seq_busy_o
);
    logic [1:0] wake_cnt;
    logic [4:0] busy_cnt;
    ////////////////////////////////////////////////////////////////
    // Slow wake so the bank must wait, not assume normal mode
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            low_power_o <= 1'b0;
            wake_cnt    <= 2'h0;
        end else if (sleep_i) begin
            low_power_o <= 1'b1;
        end else if (low_power_o && wake_i) begin
            wake_cnt <= wake_cnt + 2'h1;
            if (wake_cnt == 2'h3) begin
                low_power_o <= 1'b0;
            end
        end
    end
    // Sequencer stays busy for a while after a launch
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            busy_cnt <= 5'h00;
        end else if (seq_go_i) begin
            busy_cnt <= 5'h10;
        end else if (busy_cnt != 5'h00) begin
            busy_cnt <= busy_cnt - 5'h01;
        end
    end
    assign seq_busy_o = (busy_cnt != 5'h00);
endmodule : atf_core_model

// ==== atf_regs_chk.sv ====
// Port-level checker for the trigger/filter bank.
// Assumes atf_pkg is compiled first; bound to atf_regs.
`timescale 1ns/10ps
module atf_regs_chk
    import atf_pkg::*;
(
    input wire logic         clk_i,
    input wire logic         reset_i,
    input wire logic         clk_en_i,
    input wire atf_reg_req_t req_i,
    input wire logic         rvalid_o,
    input wire atf_launch_t  launch_o,
    input wire logic         wake_o,
    input wire logic         low_power_i,
    input wire logic         seq_busy_i,
    input wire logic         ext_clk_sel_o,
    input wire logic         unipolar_o,
    input wire logic         offset_binary_o,
    input wire logic [1:0]   filter_type_o,
    input wire logic [3:0]   rate_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // Enabled write to one offset
    sequence s_wr(a);
        clk_en_i && req_i.wr && req_i.addr == a;
    endsequence
    sequence s_bad_seq;
        s_wr(7'h07) ##0 (req_i.wdata > 8'h6f || req_i.wdata < 8'h3a);
    endsequence
    ////////////////////////////////////////////////////////////////
    a_read_answer: assert property (clk_en_i && req_i.rd |=> rvalid_o)
        else $error("read not answered");
    // Launch fields and config outputs trail the register by one cycle, hence ##1
    a_seq_addr_keep: assert property (s_bad_seq |=> ##1 $stable(launch_o.seq_addr))
        else $error("bad sequence address taken");
    a_seq_addr_take: assert property (s_wr(7'h07) ##0 !req_i.wdata[7]
        ##0 req_i.wdata[6:0] inside {[7'h3a:7'h6f]}
        |=> ##1 launch_o.seq_addr == $past(req_i.wdata[6:0], 2))
        else $error("sequence address not stored");
    a_dest_store: assert property (s_wr(7'h06) |=> ##1
        launch_o.dest == $past(req_i.wdata[6:4], 2)
        && launch_o.conv_type == $past(req_i.wdata[1:0], 2))
        else $error("conversion setup not stored");
    a_filter_take: assert property (s_wr(7'h08) |=> ##1
        filter_type_o == $past(req_i.wdata[5:4], 2) && rate_o == $past(req_i.wdata[3:0], 2))
        else $error("filter setup not stored");
    a_clk_busy_hold: assert property (s_wr(7'h09) ##0 seq_busy_i
        |=> ##1 $stable(ext_clk_sel_o))
        else $error("clock source changed mid-sequence");
    a_ctrl_take: assert property (s_wr(7'h09) ##0 !seq_busy_i |=> ##1
        ext_clk_sel_o == $past(req_i.wdata[7], 2) && unipolar_o == $past(req_i.wdata[6], 2))
        else $error("control bits not stored");
    a_unipolar_fmt: assert property (unipolar_o |-> !offset_binary_o)
        else $error("offset format in unipolar");
    a_launch_single: assert property (launch_o.conv_start |=> !launch_o.conv_start)
        else $error("launch pulse too long");
    a_wake_hold: assert property (wake_o && low_power_i && clk_en_i |=> wake_o)
        else $error("wake request dropped early");
endmodule : atf_regs_chk
bind atf_regs atf_regs_chk u_atf_regs_chk (.clk_i, .reset_i, .clk_en_i, .req_i, .rvalid_o,
    .launch_o, .wake_o, .low_power_i, .seq_busy_i, .ext_clk_sel_o, .unipolar_o,
    .offset_binary_o, .filter_type_o, .rate_o);

// ==== tb_adc_trigger_filter_config_regs.sv ====
// Self-checking bench for the trigger/filter bank.
// Assumes atf_regs, atf_core_model and the checker are compiled before it.
`timescale 1ns/10ps
module tb_adc_trigger_filter_config_regs;
    import atf_pkg::*;
    logic clk_i, reset_i, clk_en_i, pin1_in_i, irq_i, mod_i, sclk_i, lsw_i, sleep;
    logic raw_valid_i, rvalid_o, pin1_out_o, pin1_oe_o, wake_o, low_power, busy, rv_o;
    logic signed [9:0] raw_i;
    logic [7:0] rdata_o, result_o;
    atf_reg_req_t req_i;
    atf_launch_t launch_o;
    int bad_count, samples_checked, n_conv, n_seq, i;
    logic lp_at_launch;
    atf_regs #(.RESULT_W(8)) u_atf_regs (.clk_i, .reset_i, .clk_en_i, .req_i, .rdata_o,
        .rvalid_o, .pin1_in_i, .pin1_out_o, .pin1_oe_o, .low_power_i(low_power), .wake_o,
        .launch_o, .seq_busy_i(busy), .irq_i, .mod_active_i(mod_i), .sys_clk_div_i(sclk_i),
        .low_switch_i(lsw_i), .raw_valid_i, .raw_i, .result_o, .result_valid_o(rv_o),
        .ext_clk_sel_o(), .unipolar_o(), .offset_binary_o(), .filter_type_o(), .rate_o());
    atf_core_model u_atf_core_model (.clk_i, .reset_i, .sleep_i(sleep), .wake_i(wake_o),
        .seq_go_i(launch_o.seq_start), .low_power_o(low_power), .seq_busy_o(busy));
    ////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // Launch counters; power state remembered at each conversion launch
    always @(posedge clk_i) begin
        n_conv <= n_conv + int'(launch_o.conv_start);
        n_seq <= n_seq + int'(launch_o.seq_start);
        if (launch_o.conv_start) lp_at_launch <= low_power;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_i); #1 req_i = '{1'b1, 1'b0, a, d};
        @(posedge clk_i); #1 req_i = '0;
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(posedge clk_i); #1 req_i = '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_i); #1 req_i = '0;
        chk(8'(rvalid_o), 8'h01);
        chk(rdata_o, e);
    endtask : rd
    // Pin pulse of three clocks, then a bounded wait for the launch count
    task automatic trig(input int ec, input int es);
        @(posedge clk_i); #1 pin1_in_i = 1'b1;
        repeat (3) @(posedge clk_i);
        #1 pin1_in_i = 1'b0;
        for (i = 0; i < 40 && !(n_conv == ec && n_seq == es); i++) @(posedge clk_i);
        if (i == 40) begin
            bad_count++;
            results();
        end
        repeat (3) @(posedge clk_i);
        #1 chk(8'(n_conv + n_seq), 8'(ec + es));
    endtask : trig
    task automatic t_regs;
        rd(7'h05, 8'h00); rd(7'h06, 8'h00); rd(7'h07, 8'h3a);
        rd(7'h08, 8'h00); rd(7'h09, 8'h01); rd(7'h0a, 8'h00);
        wr(7'h05, 8'hd3); rd(7'h05, 8'hd3);
        wr(7'h05, 8'h47); rd(7'h05, 8'hc7);
        wr(7'h05, 8'h35); rd(7'h05, 8'h07);
        wr(7'h07, 8'h39); wr(7'h07, 8'h6f); wr(7'h07, 8'h70); rd(7'h07, 8'h6f);
        wr(7'h07, 8'hba); rd(7'h07, 8'h6f);
        wr(7'h08, 8'h3a); rd(7'h08, 8'h3a);
    endtask : t_regs
    // Push-pull pin, each output code except reserved 101 against live status inputs
    task automatic t_pin_out;
        logic [2:0] os [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
        logic [1:0] ex [7] = '{2'b00, 2'b10, 2'b11, 2'b10, 2'b10, 2'b11, 2'b10};
        for (int k = 0; k < 7; k++) begin
            wr(7'h05, {5'b11000, os[k]});
            repeat (2) @(posedge clk_i);
            #1 chk(8'(pin1_oe_o), 8'(ex[k][1]));
            if (ex[k][1]) chk(8'(pin1_out_o), 8'(ex[k][0]));
        end
        // Open-drain with a high level must release the pin
        wr(7'h05, 8'h82);
        repeat (2) @(posedge clk_i);
        #1 chk(8'(pin1_oe_o), 8'h00);
        wr(7'h05, 8'h81);
        repeat (2) @(posedge clk_i);
        #1 chk(8'({pin1_oe_o, pin1_out_o}), 8'h02);
    endtask : t_pin_out
    task automatic t_trigger;
        wr(7'h05, 8'h10);
        wr(7'h06, 8'h52);
        chk(8'(n_conv), 8'h00);
        trig(1, 0);
        chk(8'({launch_o.dest, launch_o.conv_type}), 8'h16);
        wr(7'h09, 8'h01);
        wr(7'h05, 8'h20);
        wr(7'h07, 8'h55);
        trig(1, 1);
        chk(8'(launch_o.seq_addr), 8'h55);
        wr(7'h09, 8'h81); rd(7'h09, 8'h01);
        repeat (20) @(posedge clk_i);
        wr(7'h09, 8'h81); rd(7'h09, 8'h81);
    endtask : t_trigger
    task automatic t_wake;
        wr(7'h05, 8'h10);
        @(posedge clk_i); #1 sleep = 1'b1;
        @(posedge clk_i); #1 sleep = 1'b0;
        trig(2, 1);
        chk(8'(lp_at_launch), 8'h00);
    endtask : t_wake
    // Coding change; no threshold copies live here, so none to rewrite
    task automatic res(input logic [7:0] c, input logic signed [9:0] r, input logic [7:0] e);
        wr(7'h09, c);
        @(posedge clk_i); #1 raw_i = r;
        raw_valid_i = 1'b1;
        @(posedge clk_i); #1 raw_valid_i = 1'b0;
        chk(8'(rv_o), 8'h01);
        chk(result_o, e);
    endtask : res
    initial begin
        {clk_en_i, pin1_in_i, mod_i, sclk_i, sleep, raw_valid_i} = '0;
        {irq_i, lsw_i, reset_i, clk_en_i, mod_i} = 5'h1f;
        {raw_i, req_i, bad_count, samples_checked, n_conv, n_seq} = '0;
        repeat (12) @(posedge clk_i);
        #1 reset_i = 1'b0;
        t_regs();
        t_pin_out();
        t_trigger();
        t_wake();
        res(8'h01, 10'sd300, 8'h7f); res(8'h01, -10'sd300, 8'h80);
        res(8'h01, 10'sd5, 8'h05); res(8'h21, 10'sd5, 8'h85);
        res(8'h21, -10'sd300, 8'h00); res(8'h61, 10'sd300, 8'hff);
        res(8'h61, 10'sd5, 8'h05); res(8'h61, -10'sd300, 8'h00);
        results();
    end
endmodule : tb_adc_trigger_filter_config_regs
